// ### rtl/swbs_pkg.sv
// Shared constants and types for the standby, wake and boot sequencer
package swbs_pkg;
  // Clock and boot-copy timing
  localparam int CLK_HZ = 50_000_000;
  localparam int BOOT_FIXED_US = 2000;
  localparam int BOOT_PER_KB_US = 3600;
  localparam int BOOT_FIXED_CYC = BOOT_FIXED_US * (CLK_HZ / 1_000_000);
  localparam int BOOT_PER_KB_CYC = BOOT_PER_KB_US * (CLK_HZ / 1_000_000);
  // Memory sizes and pin count
  localparam int RAM_KB = 4;
  localparam int RET_BYTES = 8;
  localparam int RET_AW = 3;
  localparam int GPIO_N = 8;
  // Clock divider: powers of two up to 128
  localparam int DIV_W = 3;
  // Transmit warm-up counts, cycles
  localparam int XO_CAL_CYC = 64;
  localparam int LC_WARM_CYC = 16;
  localparam int DIV_WARM_CYC = 8;
  localparam int PA_WARM_CYC = 8;
  localparam int TUNE_CYC = 16;
  localparam int WARM_W = 8;
  localparam int BIT_W = 16;

  typedef enum logic [2:0] {
    SWBS_STANDBY, SWBS_BOOT, SWBS_RUN
  } swbs_state_e;

  typedef enum logic [2:0] {
    SWBS_TX_IDLE, SWBS_TX_XO, SWBS_TX_LC, SWBS_TX_DIV, SWBS_TX_PA,
    SWBS_TX_TUNE, SWBS_TX_SEND
  } swbs_tx_e;

  // Power enables driven out to analog blocks
  typedef struct packed {
    logic low_power_oscillator;
    logic crystal_reference_oscillator;
    logic carrier_oscillator;
    logic divider;
    logic power_amp;
    logic antenna_tune;
    logic core_domain;
  } swbs_pwr_s;

  // Retention memory access from the core
  typedef struct packed {
    logic we;
    logic [RET_AW-1:0] addr;
    logic [7:0] wdata;
  } swbs_ret_req_s;
endpackage : swbs_pkg

// ### rtl/swbs_retention_ram.sv
// Eight-byte retention memory kept alive through standby
`timescale 1ns/100ps
module swbs_retention_ram
  import swbs_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access
  input wire logic en,
  input wire swbs_ret_req_s req,
  output logic [7:0] rdata
);
  logic [7:0] mem [RET_BYTES];

  // No reset on contents: data must survive every sequencer reset
  always_ff @(posedge clk) begin
    if (en && req.we) begin
      mem[req.addr] <= req.wdata;
    end
  end

  // Registered read port
  always_ff @(posedge clk) begin
    if (en) begin
      rdata <= mem[req.addr];
    end
  end
endmodule : swbs_retention_ram

// ### rtl/swbs_sequencer.sv
// Standby, wake, boot-copy and transmit power sequencer
`timescale 1ns/100ps
module swbs_sequencer
  import swbs_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic rst,
  // Wake sources
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire logic sleep_timer_expired,
  // Core requests
  input wire logic shutdown_req,
  input wire logic [DIV_W-1:0] clk_div_sel,
  input wire logic [2:0] image_kb,
  input wire logic [GPIO_N-1:0] periph_off,
  input wire logic xo_enable,
  // Transmit requests from the core
  input wire logic tx_start,
  input wire logic tx_valid,
  input wire logic tx_bit,
  input wire logic tx_last,
  input wire logic [BIT_W-1:0] bit_period,
  // Retention memory access
  input wire swbs_ret_req_s ret_req,
  output logic [7:0] ret_rdata,
  // Boot status and core control
  output logic core_rst,
  output logic boot_done,
  output logic boot_copy_active,
  output logic sys_clk_tick,
  output logic timer_tick,
  output logic [GPIO_N-1:0] periph_en,
  // Power enables
  output swbs_pwr_s pwr,
  // Serializer outputs
  output logic tx_ready,
  output logic tx_data,
  output logic tx_busy
);
  swbs_state_e state;
  swbs_tx_e tx_state;
  logic [GPIO_N-1:0] gpio_q;
  logic wake;
  logic [31:0] boot_cnt;
  logic [31:0] boot_len;
  logic [6:0] div_cnt;
  logic [6:0] div_max;
  logic [WARM_W-1:0] warm_cnt;
  logic [BIT_W-1:0] bit_cnt;
  logic bit_strobe;
  logic standby;
  logic [7:0] ret_q;

  // Falling edge on any pin, previous level kept in the flop
  assign wake = (|(gpio_q & ~gpio_in)) || sleep_timer_expired;
  assign standby = (state == SWBS_STANDBY);
  assign boot_len = BOOT_FIXED_CYC + 32'(image_kb) * BOOT_PER_KB_CYC;
  assign div_max = 7'((8'h01 << clk_div_sel) - 8'h01);
  assign bit_strobe = (bit_cnt == '0);

  // Pin history; idle pins are pulled high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      gpio_q <= '1;
    end else begin
      gpio_q <= gpio_in;
    end
  end

  // Top-level power state; reset lands in standby, nothing runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= SWBS_STANDBY;
    end else begin
      case (state)
        SWBS_STANDBY: begin
          if (wake) begin
            state <= SWBS_BOOT;
          end
        end
        SWBS_BOOT: begin
          if (boot_cnt == boot_len - 32'h1) begin
            state <= SWBS_RUN;
          end
        end
        SWBS_RUN: begin
          if (shutdown_req && tx_state == SWBS_TX_IDLE) begin
            state <= SWBS_STANDBY;
          end
        end
        default: begin
          state <= SWBS_STANDBY;
        end
      endcase
    end
  end

  // Boot copy timer, restarted on every wake
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      boot_cnt <= '0;
    end else if (state == SWBS_BOOT) begin
      boot_cnt <= boot_cnt + 32'h1;
    end else begin
      boot_cnt <= '0;
    end
  end

  // Core reset and done flag move together so no run before copy ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      core_rst <= 1'b1;
      boot_done <= 1'b0;
      boot_copy_active <= 1'b0;
    end else begin
      core_rst <= (state == SWBS_BOOT && boot_cnt != boot_len - 32'h1)
        || (state == SWBS_STANDBY)
        || (state == SWBS_RUN && shutdown_req
            && tx_state == SWBS_TX_IDLE);
      boot_done <= (state == SWBS_BOOT && boot_cnt == boot_len - 32'h1)
        || (state == SWBS_RUN
            && !(shutdown_req && tx_state == SWBS_TX_IDLE));
      boot_copy_active <= (state == SWBS_STANDBY && wake)
        || (state == SWBS_BOOT && boot_cnt != boot_len - 32'h1);
    end
  end

  // System clock divider; stopped with the oscillator in standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= '0;
      sys_clk_tick <= 1'b0;
      timer_tick <= 1'b0;
    end else if (standby) begin
      div_cnt <= '0;
      sys_clk_tick <= 1'b0;
      timer_tick <= 1'b0;
    end else begin
      div_cnt <= (div_cnt >= div_max) ? 7'h00 : div_cnt + 7'h01;
      sys_clk_tick <= (div_cnt >= div_max);
      timer_tick <= 1'b1;
    end
  end

  // Peripheral enables under software control, all off in standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      periph_en <= '0;
    end else begin
      periph_en <= standby ? '0 : ~periph_off;
    end
  end

  // Transmit power scheduling: crystal trim, warm-ups, tune, send
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_state <= SWBS_TX_IDLE;
      warm_cnt <= '0;
    end else begin
      warm_cnt <= warm_cnt + 8'h01;
      case (tx_state)
        SWBS_TX_IDLE: begin
          warm_cnt <= '0;
          // A start that meets a shutdown is dropped, never run in standby
          if (tx_start && state == SWBS_RUN && !shutdown_req) begin
            tx_state <= xo_enable ? SWBS_TX_XO : SWBS_TX_LC;
          end
        end
        SWBS_TX_XO: begin
          if (warm_cnt == 8'(XO_CAL_CYC - 1)) begin
            tx_state <= SWBS_TX_LC;
            warm_cnt <= '0;
          end
        end
        SWBS_TX_LC: begin
          if (warm_cnt == 8'(LC_WARM_CYC - 1)) begin
            tx_state <= SWBS_TX_DIV;
            warm_cnt <= '0;
          end
        end
        SWBS_TX_DIV: begin
          if (warm_cnt == 8'(DIV_WARM_CYC - 1)) begin
            tx_state <= SWBS_TX_PA;
            warm_cnt <= '0;
          end
        end
        SWBS_TX_PA: begin
          if (warm_cnt == 8'(PA_WARM_CYC - 1)) begin
            tx_state <= SWBS_TX_TUNE;
            warm_cnt <= '0;
          end
        end
        SWBS_TX_TUNE: begin
          if (warm_cnt == 8'(TUNE_CYC - 1)) begin
            tx_state <= SWBS_TX_SEND;
          end
        end
        SWBS_TX_SEND: begin
          if (bit_strobe && tx_valid && tx_last) begin
            tx_state <= SWBS_TX_IDLE;
          end
        end
        default: begin
          tx_state <= SWBS_TX_IDLE;
        end
      endcase
    end
  end

  // Bit pacing; each bit but the final one is held a full period, last value kept if starved
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bit_cnt <= '0;
      tx_data <= 1'b0;
      tx_ready <= 1'b0;
    end else if (tx_state == SWBS_TX_SEND) begin
      bit_cnt <= bit_strobe ? bit_period : bit_cnt - 16'h0001;
      tx_ready <= ((bit_cnt == 16'h0001) || (bit_period == '0))
        && !(bit_strobe && tx_valid && tx_last);
      if (bit_strobe && tx_valid) begin
        tx_data <= tx_bit;
      end
    end else begin
      bit_cnt <= '0;
      // Raised as send opens, so the first bit is offered like the rest
      tx_ready <= (tx_state == SWBS_TX_TUNE)
        && (warm_cnt == 8'(TUNE_CYC - 1));
      tx_data <= 1'b0;
    end
  end

  // Power enables; oscillator off only in standby
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pwr <= '0;
      tx_busy <= 1'b0;
    end else begin
      pwr.low_power_oscillator <= !standby || wake;
      pwr.core_domain <= !standby || wake;
      pwr.crystal_reference_oscillator <= (tx_state == SWBS_TX_XO);
      pwr.carrier_oscillator <= (tx_state != SWBS_TX_IDLE)
        && (tx_state != SWBS_TX_XO);
      pwr.divider <= (tx_state == SWBS_TX_DIV) || (tx_state == SWBS_TX_PA)
        || (tx_state == SWBS_TX_TUNE) || (tx_state == SWBS_TX_SEND);
      pwr.power_amp <= (tx_state == SWBS_TX_PA)
        || (tx_state == SWBS_TX_TUNE) || (tx_state == SWBS_TX_SEND);
      pwr.antenna_tune <= (tx_state == SWBS_TX_TUNE);
      tx_busy <= (tx_state != SWBS_TX_IDLE);
    end
  end

  // Retention memory is always powered and never reset
  swbs_retention_ram u_ret (
    .clk(clk),
    .en(1'b1),
    .req(ret_req),
    .rdata(ret_q)
  );

  // Output register for read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ret_rdata <= '0;
    end else begin
      ret_rdata <= ret_q;
    end
  end
endmodule : swbs_sequencer

// ### sim/swbs_sequencer_asserts.sv
// Port-level assertions for the standby, wake and boot sequencer
`timescale 1ns/100ps
module swbs_seq_chk
  import swbs_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Watched inputs
  input wire logic [GPIO_N-1:0] gpio_in,
  input wire logic sleep_timer_expired,
  input wire logic [2:0] image_kb,
  input wire logic tx_start,
  input wire logic shutdown_req,
  input wire logic [BIT_W-1:0] bit_period,
  // Watched outputs
  input wire logic core_rst,
  input wire logic boot_done,
  input wire logic boot_copy_active,
  input wire logic timer_tick,
  input wire logic [GPIO_N-1:0] periph_en,
  input wire swbs_pwr_s pwr,
  input wire logic tx_ready,
  input wire logic tx_busy
);
  logic sby;
  logic [2:0] kb;
  int cnt;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Standby as seen at the pins: core held, no copy running
  assign sby = core_rst && !boot_copy_active;
  // Copy cycle count; size is latched while still asleep
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      kb <= '0;
    end else begin
      cnt <= boot_copy_active ? cnt + 1 : 0;
      if (sby) kb <= image_kb;
    end
  end
  a_boot_standby: assert property (
    $past(rst) |-> sby && pwr == '0)
    else $error("not in standby after reset");
  a_standby_dark: assert property (
    sby [*3] |-> periph_en == '0 && !timer_tick)
    else $error("block still powered in standby");
  a_pin_wake: assert property (
    sby && |($past(gpio_in) & ~gpio_in) |-> ##1 boot_copy_active)
    else $error("pin edge did not wake");
  a_timer_wake: assert property (
    sby && sleep_timer_expired |-> ##1 boot_copy_active)
    else $error("sleep timer did not wake");
  a_copy_time: assert property (
    $rose(boot_done) |-> cnt == BOOT_FIXED_CYC + kb * BOOT_PER_KB_CYC)
    else $error("copy length wrong");
  a_core_held: assert property (
    boot_copy_active |-> core_rst && !boot_done
      && cnt < BOOT_FIXED_CYC + kb * BOOT_PER_KB_CYC)
    else $error("core free during copy");
  a_release_pair: assert property (
    $fell(core_rst) |-> $rose(boot_done) && $fell(boot_copy_active))
    else $error("release and done not together");
  a_osc_run: assert property (
    !core_rst |-> pwr.low_power_oscillator && timer_tick)
    else $error("oscillator off while running");
  a_xo_before_tx: assert property (
    tx_ready |-> !pwr.crystal_reference_oscillator
      && pwr.carrier_oscillator && pwr.divider && pwr.power_amp)
    else $error("wrong power set while sending");
  a_tx_accept: assert property (
    tx_start && !shutdown_req && !core_rst && !tx_busy
      |-> ##[1:2] tx_busy)
    else $error("transmit not started");
  a_bit_strobe: assert property (
    tx_ready && bit_period != '0 |=> !tx_ready)
    else $error("bit strobe too close");
endmodule : swbs_seq_chk

bind swbs_sequencer swbs_seq_chk u_chk (.clk(clk), .rst(rst),
  .gpio_in(gpio_in), .sleep_timer_expired(sleep_timer_expired),
  .image_kb(image_kb), .tx_start(tx_start), .shutdown_req(shutdown_req),
  .bit_period(bit_period),
  .core_rst(core_rst), .boot_done(boot_done),
  .boot_copy_active(boot_copy_active), .timer_tick(timer_tick),
  .periph_en(periph_en), .pwr(pwr), .tx_ready(tx_ready),
  .tx_busy(tx_busy));

// ### sim/swbs_core_model.sv
// Core-side model that feeds the serializer one byte of bits
`timescale 1ns/100ps
module swbs_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Serializer handshake
  input wire logic tx_ready,
  input wire logic [7:0] pattern,
  output logic tx_valid,
  output logic tx_bit,
  output logic tx_last
);
  logic [2:0] idx;
  // Next bit offered at the edge that takes the current one
  always_ff @(posedge clk or posedge rst) begin
    if (rst) idx <= '0;
    else if (tx_ready) idx <= idx + 3'h1;
  end
  // Data always ready, so the flow never starves
  assign tx_valid = 1'b1;
  assign tx_bit = pattern[idx];
  assign tx_last = idx == 3'h7;
endmodule : swbs_core_model

// ### sim/standby_wake_boot_sequencer_test.sv
// Self-checking bench for the standby, wake and boot sequencer
`timescale 1ns/100ps
module standby_wake_boot_sequencer_test;
  import swbs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [GPIO_N-1:0] gpio_in = '1;
  logic [GPIO_N-1:0] periph_off = '0;
  logic sleep_timer_expired = 1'b0;
  logic shutdown_req = 1'b0;
  logic xo_enable = 1'b0;
  logic tx_start = 1'b0;
  logic [DIV_W-1:0] clk_div_sel = '0;
  logic [2:0] image_kb = '0;
  logic [BIT_W-1:0] bit_period = '0;
  swbs_ret_req_s ret_req = '0;
  logic [7:0] pattern = '0;
  logic tx_valid, tx_bit, tx_last, core_rst, boot_done, boot_copy_active;
  logic sys_clk_tick, timer_tick, tx_ready, tx_data, tx_busy, taken, bexp;
  logic [7:0] ret_rdata, wbyte;
  logic [GPIO_N-1:0] periph_en;
  swbs_pwr_s pwr;
  logic [31:0] seed = 32'h0000c07d;
  logic [31:0] r, cnt;
  int fail_count = 0;
  int n_tests = 0;
  int nbits = 0;
  int n;

  swbs_sequencer dut (.*);
  swbs_core_model core (.*);

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run

  // Bounded wait for a level; a timeout ends the run
  task automatic wait_for(ref logic sig, input logic lvl, input int lim);
    n = 0;
    while (sig !== lvl) begin
      @(posedge clk);
      #1;
      n++;
      if (n > lim) begin
        fail_count++;
        complete_run();
      end
    end
  endtask : wait_for

  initial begin
    forever #10 clk = ~clk;
  end

  // Bit taken while ready must appear on the data output
  always @(posedge clk) begin
    taken = tx_ready === 1'b1;
    bexp = tx_bit;
    #1;
    if (taken) begin
      check(tx_data, bexp);
      nbits++;
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(core_rst, 1'b1);
    check(pwr, '0);
    r = rnd();
    wbyte = r[7:0];
    ret_req <= '{1'b1, 3'h5, wbyte};
    @(posedge clk);
    ret_req <= '{1'b0, 3'h5, 8'h00};
    periph_off <= r[15:8];
    gpio_in <= ~(8'h01 << r[18:16]);
    wait_for(boot_done, 1'b1, 100100);
    check(n, BOOT_FIXED_CYC + 1);
    check(core_rst, 1'b0);
    check(periph_en, {~periph_off});
    check(ret_rdata, wbyte);
    $display("boot test done");
    // Every divide setting, ticks counted over 256 cycles
    for (int s = 0; s < 8; s++) begin
      clk_div_sel <= s[2:0];
      repeat (4) @(posedge clk);
      cnt = 0;
      repeat (256) begin
        @(posedge clk);
        #1;
        cnt += sys_clk_tick;
      end
      check(cnt, 256 >> s);
    end
    $display("divider test done");
    r = rnd();
    pattern <= r[7:0];
    bit_period <= {13'h0, r[10:8]} + 16'h1;
    xo_enable <= 1'b1;
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(pwr.crystal_reference_oscillator, 1'b1);
    wait_for(tx_ready, 1'b1, 300);
    check(n, XO_CAL_CYC + LC_WARM_CYC + DIV_WARM_CYC + PA_WARM_CYC
      + TUNE_CYC - 3);
    check(pwr.crystal_reference_oscillator, 1'b0);
    wait_for(tx_busy, 1'b0, 2000);
    check(nbits, 8);
    // Crystal left off and fastest pacing, one bit every cycle
    r = rnd();
    @(posedge clk);
    pattern <= r[7:0];
    bit_period <= '0;
    xo_enable <= 1'b0;
    tx_start <= 1'b1;
    @(posedge clk);
    tx_start <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check(pwr.crystal_reference_oscillator, 1'b0);
    check(pwr.carrier_oscillator, 1'b1);
    wait_for(tx_ready, 1'b1, 300);
    check(n, LC_WARM_CYC + DIV_WARM_CYC + PA_WARM_CYC
      + TUNE_CYC - 3);
    wait_for(tx_busy, 1'b0, 2000);
    check(nbits, 16);
    $display("transmit test done");
    gpio_in <= '1;
    shutdown_req <= 1'b1;
    @(posedge clk);
    shutdown_req <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    check(core_rst, 1'b1);
    check(pwr, '0);
    sleep_timer_expired <= 1'b1;
    @(posedge clk);
    sleep_timer_expired <= 1'b0;
    @(posedge clk);
    #1;
    check(boot_copy_active, 1'b1);
    // Power-on reset in mid-copy must land back in standby
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    check(boot_copy_active, 1'b0);
    check(core_rst, 1'b1);
    $display("standby test done");
    complete_run();
  end
endmodule : standby_wake_boot_sequencer_test
